//--- logic/seq_divider.sv
// Unsigned restoring divider, one quotient bit per clock
`default_nettype none

module seq_divider #(
    parameter int W = 40
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rst_i,
    input  wire logic         start_i,
    input  wire logic [W-1:0] num_i,
    input  wire logic [W-1:0] den_i,
    output logic              done_o,
    output logic [W-1:0]      quot_o
);
    localparam int CW = $clog2(W + 1);

    logic [W-1:0]  rem_r;
    logic [W-1:0]  quo_r;
    logic [W-1:0]  den_r;
    logic [CW-1:0] cnt_r;
    logic          busy_r;
    logic [W:0]    trial;

    assign trial = {rem_r, quo_r[W-1]} - {1'b0, den_r};

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rem_r  <= '0;
            quo_r  <= '0;
            den_r  <= '0;
            cnt_r  <= '0;
            busy_r <= 1'b0;
            done_o <= 1'b0;
            quot_o <= '0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                rem_r  <= '0;
                quo_r  <= num_i;
                den_r  <= den_i;
                cnt_r  <= CW'(W);
                busy_r <= 1'b1;
            end else if (busy_r) begin
                if (!trial[W]) begin
                    rem_r <= trial[W-1:0];
                    quo_r <= {quo_r[W-2:0], 1'b1};
                end else begin
                    rem_r <= {rem_r[W-2:0], quo_r[W-1]};
                    quo_r <= {quo_r[W-2:0], 1'b0};
                end
                cnt_r <= cnt_r - 1'b1;
                if (cnt_r == CW'(1)) begin
                    busy_r <= 1'b0;
                    done_o <= 1'b1;
                    // Zero divisor saturates rather than returning garbage
                    quot_o <= (den_r == '0) ? '1
                              : (!trial[W] ? {quo_r[W-2:0], 1'b1} : {quo_r[W-2:0], 1'b0});
                end
            end
        end
    end

endmodule

`default_nettype wire

//--- logic/stall_level_pkg.sv
// Shared constants for the stall level selection and stall flag logic
`default_nettype none

package stall_level_pkg;

    // Setting encodings: levels in 0.1 % of rated current, frequency in 0.01 Hz,
    // compensation factor in %, flag delay in 0.1 s, analog input in mV
    localparam logic [15:0] LEVEL_DISABLED   = 16'h0000;
    localparam logic [15:0] LEVEL_ANALOG     = 16'h270F;   // 9999
    localparam logic [15:0] COMP_CONSTANT    = 16'h270F;   // 9999
    localparam logic [15:0] COMP_UNITY       = 16'h0064;   // 100 %
    localparam logic [15:0] PCT_SCALE        = 16'h0064;   // divide by 100
    localparam logic [15:0] FREQ_400HZ       = 16'h9C40;   // 40000 x 0.01 Hz
    localparam logic [15:0] SEC_FREQ_OFF     = 16'h0000;
    localparam logic [15:0] SEC_FREQ_BY_SEL  = 16'hFFFF;   // 65535 (all ones)
    localparam logic [15:0] TIMER_NOW        = 16'h0000;
    localparam logic [15:0] TIMER_OFF        = 16'h270F;   // 9999
    localparam logic [15:0] FAULT_FREQ       = 16'h0032;   // 0.5 Hz
    localparam logic [15:0] FULL_SCALE_10V   = 16'h2710;   // 10000 mV
    localparam logic [15:0] FULL_SCALE_5V    = 16'h1388;   // 5000 mV
    localparam logic [7:0]  OUT_FUNC_POS     = 8'h03;      // code 3
    localparam logic [7:0]  OUT_FUNC_NEG     = 8'h67;      // code 103
    localparam logic [7:0]  IN_FUNC_SECOND   = 8'h03;      // code 3

    // Timing
    localparam int CLK_HZ        = 10_000_000;
    localparam int FLAG_HOLD_MS  = 100;
    localparam int TICK_MS       = 100;                    // delay timer resolution
    localparam int FAULT_HOLD_S  = 3;
    localparam int HOLD_CYCLES   = (FLAG_HOLD_MS * (CLK_HZ / 1000));
    localparam int TICK_CYCLES   = (TICK_MS * (CLK_HZ / 1000));
    localparam logic [15:0] FAULT_TICKS = 16'(FAULT_HOLD_S * 1000 / TICK_MS);
    localparam int CNT_W         = 32;
    localparam int DIV_W         = 40;

    typedef enum logic [3:0] {
        CALC_A  = 4'b0001,
        CALC_B  = 4'b0010,
        CALC_T  = 4'b0100,
        CALC_AN = 4'b1000
    } calc_state_t;

endpackage

`default_nettype wire

//--- logic/stall_level_select.sv
// Stall prevention level selection, stall flag, flag timer and stall hold fault
//
// How it works
// - On engagement the stall flag rises and stays high longer than 100 ms.
// - Flag drops once current is at or below the active level.
// - Delay setting 0 immediate, 0.1-25 s delayed, 9999 never asserts.
// - Flag reaches a terminal with function code 3 true or 103 inverted.
// - Engaged at 0.5 Hz or less for 3 s raises sticky fault, output off.
// - Above reduction start frequency the level follows the reduction formula.
// - Compensation factor 9999 keeps the primary level up to 400 Hz.
// - Second level applies from 0 Hz to second frequency; acceleration uses primary.
// - Second frequency 0 disables; otherwise active at or below it, not accelerating.
// - Second frequency 65535 picks second level while select input is on.
// - When both levels could apply in frequency mode, the smaller one wins.
// - In analog mode the select input swaps analog level for second level.
// - Second level 0 % with frequency mode gives 0 % at or above second frequency.
// - Select input comes from the terminal whose function code is 3.
// - Select input also enables all other second-function settings.
// - Primary level 9999 takes the level from the analog input, 5 V or 10 V span.
// - Zero-input and full-input settings give the level at 0 V and full scale.
// - Analog mode disables the fast-response current limit.
// - Analog mode disables other uses of the analog input.
// - Engaged: hold acceleration, decelerate at constant speed, hold deceleration.
// - Primary level 0 disables stall prevention; otherwise percent of rated current.
`default_nettype none

module stall_level_select
    import stall_level_pkg::*;
#(
    parameter int HOLD_CYC = HOLD_CYCLES,
    parameter int TICK_CYC = TICK_CYCLES
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] out_current_i,
    input  wire logic [15:0] out_freq_i,
    input  wire logic        accel_i,
    input  wire logic        decel_i,
    input  wire logic [15:0] primary_stall_level_i,
    input  wire logic [15:0] high_speed_comp_factor_i,
    input  wire logic [15:0] reduction_start_freq_i,
    input  wire logic [15:0] second_stall_level_i,
    input  wire logic [15:0] second_stall_freq_i,
    input  wire logic [15:0] level_at_zero_input_i,
    input  wire logic [15:0] level_at_full_input_i,
    input  wire logic        analog_range_select_i,
    input  wire logic [15:0] analog_in_mv_i,
    input  wire logic [15:0] flag_delay_timer_i,
    input  wire logic [7:0]  output_terminal_function_i,
    input  wire logic [7:0]  input_terminal_function_i,
    input  wire logic        input_terminal_i,
    input  wire logic        fast_limit_request_i,
    output logic [15:0]      active_level_o,
    output logic             overload_stall_flag_o,
    output logic             flag_terminal_o,
    output logic             stall_hold_fault_o,
    output logic             drive_enable_o,
    output logic             hold_accel_o,
    output logic             force_decel_o,
    output logic             hold_decel_o,
    output logic             second_function_select_o,
    output logic             fast_limit_enable_o,
    output logic             aux_input_enable_o
);

    function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
        min16 = (a < b) ? a : b;
    endfunction

    function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
        absdiff = (a >= b) ? (a - b) : (b - a);
    endfunction

    // ---------------- Setting decode ----------------
    logic enabled;
    logic analog_mode;
    logic sel_in;
    assign enabled     = (primary_stall_level_i != LEVEL_DISABLED);
    assign analog_mode = (primary_stall_level_i == LEVEL_ANALOG);
    assign sel_in      = (input_terminal_function_i == IN_FUNC_SECOND)
                         && input_terminal_i;

    // ---------------- Shared divider for the level arithmetic ----------------
    calc_state_t      st_r;
    logic             start_r;
    logic             div_done;
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_num;
    logic [DIV_W-1:0] div_den;
    logic [15:0]      a_r;
    logic [15:0]      b_r;
    logic [15:0]      hi_level_r;
    logic [15:0]      an_level_r;
    logic [15:0]      vmax;
    logic [15:0]      vin;
    logic [15:0]      l_minus_a;
    logic [15:0]      c_minus_u;
    logic             neg_t;

    assign vmax      = analog_range_select_i ? FULL_SCALE_10V : FULL_SCALE_5V;
    assign vin       = min16(analog_in_mv_i, vmax);
    assign l_minus_a = absdiff(primary_stall_level_i, a_r);
    assign c_minus_u = absdiff(high_speed_comp_factor_i, COMP_UNITY);
    assign neg_t     = (primary_stall_level_i < a_r) != (high_speed_comp_factor_i < COMP_UNITY);

    always_comb begin
        div_num = '0;
        div_den = '0;
        case (st_r)
            CALC_A: begin
                div_num = DIV_W'(reduction_start_freq_i) * DIV_W'(primary_stall_level_i);
                div_den = DIV_W'(out_freq_i);
            end
            CALC_B: begin
                div_num = DIV_W'(reduction_start_freq_i) * DIV_W'(primary_stall_level_i);
                div_den = DIV_W'(FREQ_400HZ);
            end
            CALC_T: begin
                div_num = DIV_W'(b_r) * DIV_W'(l_minus_a) * DIV_W'(c_minus_u);
                div_den = DIV_W'(absdiff(primary_stall_level_i, b_r)) * DIV_W'(PCT_SCALE);
            end
            CALC_AN: begin
                div_num = DIV_W'(absdiff(level_at_full_input_i, level_at_zero_input_i))
                          * DIV_W'(vin);
                div_den = DIV_W'(vmax);
            end
            default: begin
                div_num = '0;
                div_den = '0;
            end
        endcase
    end

    seq_divider #(.W(DIV_W)) u_div (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .start_i   (start_r),
        .num_i     (div_num),
        .den_i     (div_den),
        .done_o    (div_done),
        .quot_o    (div_q)
    );

    // The level calculation loops forever; each result is at most four divisions old
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st_r       <= CALC_A;
            start_r    <= 1'b1;
            a_r        <= '0;
            b_r        <= '0;
            hi_level_r <= '0;
            an_level_r <= '0;
        end else begin
            start_r <= div_done;
            if (div_done) begin
                case (st_r)
                    CALC_A: begin
                        a_r  <= (div_q > DIV_W'(16'hFFFF)) ? 16'hFFFF : div_q[15:0];
                        st_r <= CALC_B;
                    end
                    CALC_B: begin
                        b_r  <= div_q[15:0];
                        st_r <= CALC_T;
                    end
                    CALC_T: begin
                        // A + B*(L-A)/(L-B)*(C-100)/100, clamped at zero
                        if (neg_t) begin
                            hi_level_r <= (div_q >= DIV_W'(a_r)) ? '0
                                          : a_r - div_q[15:0];
                        end else begin
                            hi_level_r <= a_r + div_q[15:0];
                        end
                        st_r <= CALC_AN;
                    end
                    CALC_AN: begin
                        if (level_at_full_input_i >= level_at_zero_input_i) begin
                            an_level_r <= level_at_zero_input_i + div_q[15:0];
                        end else begin
                            an_level_r <= level_at_zero_input_i - div_q[15:0];
                        end
                        st_r <= CALC_A;
                    end
                    default: begin
                        st_r <= CALC_A;
                    end
                endcase
            end
        end
    end

    // ---------------- Active level selection ----------------
    logic [15:0] base_level;
    logic [15:0] level_nxt;
    logic        by_sel;
    logic        sec_on;

    assign by_sel = (second_stall_freq_i == SEC_FREQ_BY_SEL);

    always_comb begin
        if (analog_mode) begin
            base_level = an_level_r;
        end else if (high_speed_comp_factor_i != COMP_CONSTANT
                     && out_freq_i > reduction_start_freq_i) begin
            base_level = hi_level_r;
        end else begin
            base_level = primary_stall_level_i;
        end
    end

    assign sec_on = !accel_i && second_stall_freq_i != SEC_FREQ_OFF
                    && out_freq_i <= second_stall_freq_i;

    always_comb begin
        if (by_sel) begin
            level_nxt = sel_in ? second_stall_level_i : base_level;
        end else if (second_stall_freq_i != SEC_FREQ_OFF && second_stall_level_i == '0
                     && out_freq_i >= second_stall_freq_i) begin
            level_nxt = '0;
        end else if (sec_on && second_stall_level_i != '0) begin
            level_nxt = min16(base_level, second_stall_level_i);
        end else begin
            level_nxt = base_level;
        end
    end

    logic engaged_r;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            active_level_o <= '0;
            engaged_r      <= 1'b0;
        end else begin
            active_level_o <= level_nxt;
            engaged_r      <= enabled && (out_current_i > level_nxt);
        end
    end

    // ---------------- Corrective action and mode outputs ----------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            hold_accel_o             <= 1'b0;
            force_decel_o            <= 1'b0;
            hold_decel_o             <= 1'b0;
            second_function_select_o <= 1'b0;
            fast_limit_enable_o      <= 1'b0;
            aux_input_enable_o       <= 1'b0;
        end else begin
            hold_accel_o             <= engaged_r && accel_i;
            force_decel_o            <= engaged_r && !accel_i && !decel_i;
            hold_decel_o             <= engaged_r && !accel_i && decel_i;
            second_function_select_o <= sel_in;
            fast_limit_enable_o      <= fast_limit_request_i && !analog_mode;
            aux_input_enable_o       <= !analog_mode;
        end
    end

    // ---------------- Flag delay timer ----------------
    logic [CNT_W-1:0] dly_pre_r;
    logic [15:0]      dly_ticks_r;
    logic             delay_done;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            dly_pre_r   <= '0;
            dly_ticks_r <= '0;
        end else if (!engaged_r) begin
            dly_pre_r   <= '0;
            dly_ticks_r <= '0;
        end else if (dly_ticks_r < flag_delay_timer_i) begin
            if (dly_pre_r == CNT_W'(TICK_CYC - 1)) begin
                dly_pre_r   <= '0;
                dly_ticks_r <= dly_ticks_r + 1'b1;
            end else begin
                dly_pre_r <= dly_pre_r + 1'b1;
            end
        end
    end

    assign delay_done = engaged_r && flag_delay_timer_i != TIMER_OFF
                        && (flag_delay_timer_i == TIMER_NOW
                            || dly_ticks_r >= flag_delay_timer_i);

    // ---------------- Stall flag with minimum hold ----------------
    logic [CNT_W-1:0] hold_cnt_r;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            overload_stall_flag_o <= 1'b0;
            hold_cnt_r            <= '0;
        end else if (!overload_stall_flag_o) begin
            hold_cnt_r <= '0;
            if (delay_done) begin
                overload_stall_flag_o <= 1'b1;
            end
        end else if (hold_cnt_r < CNT_W'(HOLD_CYC)) begin
            hold_cnt_r <= hold_cnt_r + 1'b1;
        end else if (!engaged_r) begin
            overload_stall_flag_o <= 1'b0;
        end
    end

    // Terminal follows one cycle behind the flag so both come from flops
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            flag_terminal_o <= 1'b0;
        end else if (output_terminal_function_i == OUT_FUNC_POS) begin
            flag_terminal_o <= overload_stall_flag_o;
        end else if (output_terminal_function_i == OUT_FUNC_NEG) begin
            flag_terminal_o <= !overload_stall_flag_o;
        end else begin
            flag_terminal_o <= 1'b0;
        end
    end

    // ---------------- Stall hold fault ----------------
    logic [CNT_W-1:0] flt_pre_r;
    logic [15:0]      flt_ticks_r;
    logic             low_stall;

    assign low_stall = engaged_r && out_freq_i <= FAULT_FREQ;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            flt_pre_r          <= '0;
            flt_ticks_r        <= '0;
            stall_hold_fault_o <= 1'b0;
            drive_enable_o     <= 1'b0;
        end else begin
            drive_enable_o <= !stall_hold_fault_o;
            if (!low_stall) begin
                flt_pre_r   <= '0;
                flt_ticks_r <= '0;
            end else if (flt_ticks_r >= FAULT_TICKS) begin
                stall_hold_fault_o <= 1'b1;
                drive_enable_o     <= 1'b0;
            end else if (flt_pre_r == CNT_W'(TICK_CYC - 1)) begin
                flt_pre_r   <= '0;
                flt_ticks_r <= flt_ticks_r + 1'b1;
            end else begin
                flt_pre_r <= flt_pre_r + 1'b1;
            end
        end
    end

    // ---------------- Assertions ----------------
    flag_min_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(overload_stall_flag_o) |-> overload_stall_flag_o [*8])
        else $error("stall flag released too early");

    flag_release_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $fell(overload_stall_flag_o) |-> !$past(engaged_r)
        && $past(hold_cnt_r) >= CNT_W'(HOLD_CYC))
        else $error("stall flag fell while engaged or before hold");

    flag_suppress_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(overload_stall_flag_o) |-> $past(flag_delay_timer_i) != TIMER_OFF
        && $past(engaged_r))
        else $error("stall flag rose while suppressed or idle");

    term_polarity_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !$past(rst_i) && $past(output_terminal_function_i) == OUT_FUNC_NEG
        |-> flag_terminal_o == !$past(overload_stall_flag_o))
        else $error("inverted flag terminal wrong");

    fault_sticky_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        stall_hold_fault_o |=> stall_hold_fault_o && !drive_enable_o)
        else $error("stall hold fault not held");

    disabled_idle_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !enabled |=> !engaged_r ##1 !hold_accel_o && !force_decel_o)
        else $error("stall engaged while disabled");

    second_select_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        by_sel && sel_in |=> active_level_o == $past(second_stall_level_i))
        else $error("second level not chosen by select input");

    accel_primary_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        accel_i && !by_sel && !analog_mode && high_speed_comp_factor_i == COMP_CONSTANT
        && (second_stall_level_i != '0 || second_stall_freq_i == SEC_FREQ_OFF)
        |=> active_level_o == $past(primary_stall_level_i))
        else $error("non primary level during acceleration");

    analog_fast_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        analog_mode |=> !fast_limit_enable_o && !aux_input_enable_o)
        else $error("analog mode left other functions on");

endmodule

`default_nettype wire

//--- tb/drive_sup_model.sv
// Drive supervisor model: supplies measured current, frequency and ramp state
`default_nettype none

module drive_sup_model (
    input  wire logic        clk_sys_i,
    input  wire logic [15:0] cur_i,
    input  wire logic [15:0] frq_i,
    input  wire logic        acc_i,
    input  wire logic        dec_i,
    output logic [15:0]      cur_o,
    output logic [15:0]      frq_o,
    output logic             acc_o,
    output logic             dec_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Measurements land one sample late, as from a real converter
    always_ff @(posedge clk_sys_i) begin
        cur_o <= cur_i;
        frq_o <= frq_i;
        acc_o <= acc_i;
        dec_o <= dec_i;
    end
endmodule

`default_nettype wire

//--- tb/stall_level_select_tb.sv
// Self-checking bench for stall level selection and stall flag
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h expected %h", $time, (a), (e)); end end

module stall_level_select_tb
    import stall_level_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, accel_i, decel_i, acc_c = 1'b0, dec_c = 1'b0;
    logic analog_range_select_i = 1'b1, input_terminal_i = 1'b0, fast_limit_request_i = 1'b0;
    logic [15:0] out_current_i, out_freq_i, cur_c = 16'h03E8, frq_c = 16'h07D0;
    logic [15:0] primary_stall_level_i = 16'h04B0, high_speed_comp_factor_i = COMP_CONSTANT;
    logic [15:0] reduction_start_freq_i = 16'h0BB8, second_stall_level_i = 16'h0320;
    logic [15:0] second_stall_freq_i = SEC_FREQ_OFF, flag_delay_timer_i = TIMER_NOW;
    logic [15:0] level_at_zero_input_i = 16'h03E8, level_at_full_input_i = 16'h05DC;
    logic [15:0] analog_in_mv_i = 16'h1388, active_level_o;
    logic [7:0] output_terminal_function_i = OUT_FUNC_NEG, input_terminal_function_i = 8'h03;
    logic overload_stall_flag_o, flag_terminal_o, stall_hold_fault_o, drive_enable_o;
    logic hold_accel_o, force_decel_o, hold_decel_o, second_function_select_o;
    logic fast_limit_enable_o, aux_input_enable_o;
    int fails = 0, total_checks = 0, cyc = 0;

    // Short hold and tick keep the run brief; expectations use these same values
    stall_level_select #(.HOLD_CYC(20), .TICK_CYC(10)) u_dut (.clk_sys_i, .rst_i,
        .out_current_i, .out_freq_i, .accel_i, .decel_i, .primary_stall_level_i,
        .high_speed_comp_factor_i, .reduction_start_freq_i, .second_stall_level_i,
        .second_stall_freq_i, .level_at_zero_input_i, .level_at_full_input_i,
        .analog_range_select_i, .analog_in_mv_i, .flag_delay_timer_i,
        .output_terminal_function_i, .input_terminal_function_i, .input_terminal_i,
        .fast_limit_request_i, .active_level_o, .overload_stall_flag_o, .flag_terminal_o,
        .stall_hold_fault_o, .drive_enable_o, .hold_accel_o, .force_decel_o, .hold_decel_o,
        .second_function_select_o, .fast_limit_enable_o, .aux_input_enable_o);
    drive_sup_model u_sup (.clk_sys_i, .cur_i(cur_c), .frq_i(frq_c), .acc_i(acc_c),
        .dec_i(dec_c), .cur_o(out_current_i), .frq_o(out_freq_i), .acc_o(accel_i),
        .dec_o(decel_i));

    always #50 clk_sys_i = ~clk_sys_i;

    task go(int n);
        repeat (n) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask

    task final_report;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            final_report;
        end
    end

    initial begin
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        go(4);
        `CHK(active_level_o, 16'h04B0)
        `CHK(flag_terminal_o, 1'b1)
        @(posedge clk_sys_i);
        output_terminal_function_i <= OUT_FUNC_POS;
        cur_c <= 16'h0514;
        go(6);
        `CHK(overload_stall_flag_o, 1'b1)
        `CHK(flag_terminal_o, 1'b1)
        `CHK(force_decel_o, 1'b1)
        @(posedge clk_sys_i);
        cur_c <= 16'h04B0;
        go(5);
        `CHK(overload_stall_flag_o, 1'b1)
        go(40);
        `CHK(overload_stall_flag_o, 1'b0)
        @(posedge clk_sys_i);
        flag_delay_timer_i <= 16'h0003;
        cur_c <= 16'h0514;
        go(20);
        `CHK(overload_stall_flag_o, 1'b0)
        go(20);
        `CHK(overload_stall_flag_o, 1'b1)
        @(posedge clk_sys_i);
        cur_c <= 16'h03E8;
        flag_delay_timer_i <= TIMER_OFF;
        go(40);
        @(posedge clk_sys_i);
        cur_c <= 16'h0514;
        go(40);
        `CHK(overload_stall_flag_o, 1'b0)
        @(posedge clk_sys_i);
        cur_c <= 16'h03E8;
        second_stall_freq_i <= 16'h0BB8;
        go(4);
        `CHK(active_level_o, 16'h0320)
        @(posedge clk_sys_i);
        acc_c <= 1'b1;
        go(4);
        `CHK(active_level_o, 16'h04B0)
        @(posedge clk_sys_i);
        acc_c <= 1'b0;
        second_stall_level_i <= 16'h05DC;
        go(4);
        `CHK(active_level_o, 16'h04B0)
        @(posedge clk_sys_i);
        second_stall_freq_i <= SEC_FREQ_BY_SEL;
        input_terminal_i <= 1'b1;
        go(4);
        `CHK(active_level_o, 16'h05DC)
        `CHK(second_function_select_o, 1'b1)
        @(posedge clk_sys_i);
        input_terminal_function_i <= 8'h00;
        go(4);
        `CHK(active_level_o, 16'h04B0)
        `CHK(second_function_select_o, 1'b0)
        @(posedge clk_sys_i);
        input_terminal_function_i <= IN_FUNC_SECOND;
        primary_stall_level_i <= LEVEL_ANALOG;
        second_stall_freq_i <= SEC_FREQ_OFF;
        fast_limit_request_i <= 1'b1;
        go(400);
        `CHK(active_level_o, 16'h04E2)
        `CHK(aux_input_enable_o, 1'b0)
        `CHK(fast_limit_enable_o, 1'b0)
        @(posedge clk_sys_i);
        analog_range_select_i <= 1'b0;
        analog_in_mv_i <= 16'h09C4;
        go(400);
        `CHK(active_level_o, 16'h04E2)
        @(posedge clk_sys_i);
        second_stall_freq_i <= SEC_FREQ_BY_SEL;
        go(4);
        `CHK(active_level_o, 16'h05DC)
        @(posedge clk_sys_i);
        primary_stall_level_i <= 16'h04B0;
        second_stall_freq_i <= SEC_FREQ_OFF;
        high_speed_comp_factor_i <= 16'h00C8;
        frq_c <= 16'h1770;
        go(400);
        // A = 600, B = 90, level = 600 + 90*600/1110 truncated
        `CHK(active_level_o, 16'h0288)
        @(posedge clk_sys_i);
        second_stall_level_i <= 16'h0000;
        second_stall_freq_i <= 16'h0BB8;
        go(4);
        `CHK(active_level_o, 16'h0000)
        @(posedge clk_sys_i);
        primary_stall_level_i <= LEVEL_DISABLED;
        go(4);
        `CHK(force_decel_o, 1'b0)
        @(posedge clk_sys_i);
        primary_stall_level_i <= 16'h04B0;
        second_stall_freq_i <= SEC_FREQ_OFF;
        frq_c <= 16'h0028;
        dec_c <= 1'b1;
        cur_c <= 16'h0514;
        flag_delay_timer_i <= TIMER_NOW;
        go(8);
        `CHK(hold_decel_o, 1'b1)
        go(320);
        `CHK(stall_hold_fault_o, 1'b1)
        `CHK(drive_enable_o, 1'b0)
        final_report;
    end
endmodule

`default_nettype wire
